// ===== ccfg_dev.sv
// device end: two-wire target with charger register file
`timescale 1ns/1ps
`default_nettype none
module ccfg_dev
    import ccfg_pkg::*;
#(
    parameter int NVM_CYC = NVM_WRITE_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    ccfg_link_if.dev link,
    output logic [7:0] chargeCurrent_r,
    output logic nvmBusy_r,
    output logic locked_r
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01, ST_ADDR = 6'h02, ST_PTR = 6'h04,
        ST_WR = 6'h08, ST_RD = 6'h10, ST_SKIP = 6'h20
    } ccfg_state_e;
    ccfg_state_e state_r;
    logic [1:0] sclSync_r, sdaSync_r;
    logic sclD_r, sdaD_r;
    logic [7:0] nvm_r [16];
    logic [7:0] live_r [NDEV_REGS];
    logic [7:0] stage_r [16];
    logic [15:0] stageVal_r;
    logic [7:0] shift_r, ptr_r, txByte_r;
    logic [3:0] bitCnt_r;
    logic ackPhase_r, rdDir_r, sdaOe_r;
    logic [31:0] nvmCnt_r;
    logic [6:0] target;
    logic sclRise, sclFall, startCond, stopCond, shadowOk, nvmTarget;
    logic [7:0] rdData;
    //////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclSync_r <= 2'h3;
            sdaSync_r <= 2'h3;
            sclD_r <= 1'b1;
            sdaD_r <= 1'b1;
        end else begin
            sclSync_r <= {sclSync_r[0], link.scl};
            sdaSync_r <= {sdaSync_r[0], link.sda};
            sclD_r <= sclSync_r[1];
            sdaD_r <= sdaSync_r[1];
        end
    end
    assign sclRise = sclSync_r[1] && !sclD_r;
    assign sclFall = !sclSync_r[1] && sclD_r;
    assign startCond = sclSync_r[1] && sclD_r && sdaD_r && !sdaSync_r[1];
    assign stopCond = sclSync_r[1] && sclD_r && !sdaD_r && sdaSync_r[1];
    // address register lives at 0F[6:0]
    assign target = nvm_r[4'hF][6:0];
    assign shadowOk = live_r[ADDR_LOCK_CTRL[5:0]][SHADOW_EN_BIT]
        && live_r[ADDR_CMD[5:0]][CMD_SHADOW_BIT];
    assign nvmTarget = (ptr_r <= ADDR_NV_HI) && !(ptr_r <= ADDR_SHADOW_HI && shadowOk);
    assign rdData = (ptr_r <= ADDR_NV_HI || (ptr_r >= ADDR_VOL_LO && ptr_r <= ADDR_VOL_HI))
        ? live_r[ptr_r[5:0]] : 8'h00;
    //////////////////////////////////////////////////////////////////
    // protocol engine
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            bitCnt_r <= 4'h0;
            ackPhase_r <= 1'b0;
            rdDir_r <= 1'b0;
            sdaOe_r <= 1'b0;
            ptr_r <= 8'h00;
            txByte_r <= 8'h00;
        end else if (stopCond) begin
            state_r <= ST_IDLE;
            sdaOe_r <= 1'b0;
        end else if (startCond) begin
            state_r <= ST_ADDR;
            bitCnt_r <= 4'h0;
            ackPhase_r <= 1'b0;
            sdaOe_r <= 1'b0;
        end else if (state_r != ST_IDLE && state_r != ST_SKIP) begin
            if (sclRise && !ackPhase_r) begin
                shift_r <= {shift_r[6:0], sdaSync_r[1]};
                bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclRise && ackPhase_r && state_r == ST_RD) begin
                if (sdaSync_r[1]) begin
                    state_r <= ST_SKIP;
                end else begin
                    ptr_r <= ptr_r + 8'h01;
                end
            end else if (sclFall) begin
                if (!ackPhase_r && bitCnt_r == 4'h8) begin
                    ackPhase_r <= 1'b1;
                    bitCnt_r <= 4'h0;
                    sdaOe_r <= 1'b0;
                    if (state_r == ST_ADDR) begin
                        if (shift_r[7:1] == target) begin
                            rdDir_r <= shift_r[0];
                            sdaOe_r <= 1'b1;
                        end else begin
                            state_r <= ST_SKIP;
                        end
                    end else if (state_r != ST_RD) begin
                        sdaOe_r <= 1'b1;
                        if (state_r == ST_PTR) begin
                            ptr_r <= shift_r;
                        end
                    end
                end else if (ackPhase_r) begin
                    ackPhase_r <= 1'b0;
                    sdaOe_r <= 1'b0;
                    if (state_r == ST_ADDR) begin
                        state_r <= rdDir_r ? ST_RD : ST_PTR;
                    end else if (state_r == ST_PTR) begin
                        state_r <= ST_WR;
                    end else if (state_r == ST_WR) begin
                        // page wrap
                        ptr_r <= {ptr_r[7:PAGE_BITS], ptr_r[PAGE_BITS-1:0] + 4'h1};
                    end
                    if (state_r == ST_RD || (state_r == ST_ADDR && rdDir_r)) begin
                        txByte_r <= {rdData[6:0], 1'b0};
                        sdaOe_r <= !rdData[7];
                        // rises count all eight bits, msb already out
                        bitCnt_r <= 4'h0;
                    end
                end else if (state_r == ST_RD && bitCnt_r != 4'h0) begin
                    sdaOe_r <= !txByte_r[7];
                    txByte_r <= {txByte_r[6:0], 1'b0};
                end
            end else if (sclRise && state_r == ST_RD && !ackPhase_r) begin
                bitCnt_r <= bitCnt_r + 4'h1;
            end
        end
    end
    //////////////////////////////////////////////////////////////////
    // register file, staging and commit
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NDEV_REGS; i++) begin
                // live copy of 0F must read back the reset address
                live_r[i] <= (i == 15) ? {1'b0, DEF_TARGET} : 8'h00;
            end
            for (int i = 0; i < 16; i++) begin
                nvm_r[i] <= (i == 15) ? {1'b0, DEF_TARGET} : 8'h00;
                stage_r[i] <= 8'h00;
            end
            stageVal_r <= 16'h0000;
            nvmCnt_r <= 32'h0;
            nvmBusy_r <= 1'b0;
            locked_r <= 1'b0;
            chargeCurrent_r <= 8'h00;
        end else begin
            if (sclFall && !ackPhase_r && bitCnt_r == 4'h8 && state_r == ST_WR) begin
                if (nvmTarget) begin
                    if (!locked_r && CFG_PRESENT[ptr_r[3:0]]) begin
                        stage_r[ptr_r[3:0]] <= shift_r;
                        stageVal_r[ptr_r[3:0]] <= 1'b1;
                    end
                end else if (ptr_r <= ADDR_SHADOW_HI
                        || (ptr_r >= ADDR_VOL_LO && ptr_r <= ADDR_VOL_HI)) begin
                    live_r[ptr_r[5:0]] <= shift_r;
                end
            end
            if (stopCond && stageVal_r != 16'h0000 && !nvmBusy_r) begin
                nvmBusy_r <= 1'b1;
                nvmCnt_r <= NVM_CYC;
            end else if (nvmBusy_r) begin
                if (nvmCnt_r <= 32'h1) begin
                    nvmBusy_r <= 1'b0;
                    for (int i = 0; i < 16; i++) begin
                        if (stageVal_r[i]) begin
                            nvm_r[i] <= stage_r[i];
                            live_r[i] <= stage_r[i];
                        end
                    end
                    stageVal_r <= 16'h0000;
                    if (stageVal_r[ADDR_LOCK_CTRL[3:0]] && stage_r[ADDR_LOCK_CTRL[3:0]][LOCK_BIT]) begin
                        locked_r <= 1'b1;
                    end
                end
                nvmCnt_r <= nvmCnt_r - 32'h1;
            end
            chargeCurrent_r <= live_r[ADDR_CHARGE_CUR[5:0]];
        end
    end
    assign link.sdaDevOut = 1'b0;
    assign link.sdaDevOe = sdaOe_r;
endmodule // ccfg_dev
`default_nettype wire

// ===== ccfg_host.sv
// host end: AHB-Lite driven two-wire byte master
`timescale 1ns/1ps
`default_nettype none
module ccfg_host
    import ccfg_pkg::*;
#(
    parameter int HALF_CYC = SCL_HALF_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    ccfg_link_if.host link,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    typedef enum logic [4:0] {
        HS_IDLE = 5'h01, HS_START = 5'h02, HS_BIT = 5'h04, HS_STOP = 5'h08, HS_DONE = 5'h10
    } ccfg_hstate_e;
    ccfg_hstate_e st_r;
    logic [1:0] sdaSync_r;
    logic [15:0] cnt_r;
    logic [3:0] bitIdx_r;
    logic [8:0] sh_r;
    logic [7:0] wdata_r, rdata_r;
    logic [4:0] ctrl_r;
    logic ack_r, busy_r, sclO_r, sdaO_r, phase_r;
    logic wrPend_r, rdPend_r;
    logic [7:0] aOff_r;
    logic go;
    assign hresp = 1'b0;
    assign hreadyout = 1'b1;
    //////////////////////////////////////////////////////////////////
    // bus slave: zero wait states
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wrPend_r <= 1'b0;
            aOff_r <= 8'h00;
            hrdata <= 32'h0;
        end else begin
            wrPend_r <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                aOff_r <= haddr[7:0];
                if (haddr[7:0] == HREG_STATUS) begin
                    hrdata <= {30'h0, ack_r, busy_r};
                end else if (haddr[7:0] == HREG_RDATA) begin
                    hrdata <= {24'h0, rdata_r};
                end else if (haddr[7:0] == HREG_WDATA) begin
                    hrdata <= {24'h0, wdata_r};
                end else begin
                    hrdata <= 32'h0;
                end
            end
        end
    end
    assign go = wrPend_r && aOff_r == HREG_CTRL && hwdata[CTRL_GO] && !busy_r;
    //////////////////////////////////////////////////////////////////
    // bit engine: scl driven low half, released high half
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sdaSync_r <= 2'h3;
        end else begin
            sdaSync_r <= {sdaSync_r[0], link.sda};
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= HS_IDLE;
            cnt_r <= 16'h0;
            bitIdx_r <= 4'h0;
            sh_r <= 9'h1FF;
            wdata_r <= 8'h00;
            rdata_r <= 8'h00;
            ctrl_r <= 5'h00;
            ack_r <= 1'b0;
            busy_r <= 1'b0;
            sclO_r <= 1'b1;
            sdaO_r <= 1'b1;
            phase_r <= 1'b0;
        end else begin
            if (wrPend_r && aOff_r == HREG_WDATA && !busy_r) begin
                wdata_r <= hwdata[7:0];
            end
            if (go) begin
                busy_r <= 1'b1;
                ctrl_r <= hwdata[4:0];
                cnt_r <= 16'(HALF_CYC);
                // read byte: release sda, ack bit from nack flag
                sh_r <= hwdata[CTRL_READ] ? {8'hFF, hwdata[CTRL_NACK]} : {wdata_r, 1'b1};
                bitIdx_r <= 4'h0;
                phase_r <= 1'b0;
                st_r <= hwdata[CTRL_START] ? HS_START : HS_BIT;
                if (hwdata[CTRL_START]) begin
                    sclO_r <= 1'b1;
                    sdaO_r <= 1'b1;
                end
            end else if (st_r != HS_IDLE) begin
                if (cnt_r != 16'h0) begin
                    cnt_r <= cnt_r - 16'h1;
                end else begin
                    cnt_r <= 16'(HALF_CYC);
                    case (st_r)
                        HS_START: begin
                            if (!phase_r) begin
                                sdaO_r <= 1'b0;
                                phase_r <= 1'b1;
                            end else begin
                                sclO_r <= 1'b0;
                                phase_r <= 1'b0;
                                st_r <= HS_BIT;
                            end
                        end
                        HS_BIT: begin
                            if (!phase_r) begin
                                sclO_r <= 1'b0;
                                sdaO_r <= sh_r[8];
                                phase_r <= 1'b1;
                            end else begin
                                sclO_r <= 1'b1;
                                phase_r <= 1'b0;
                                sh_r <= {sh_r[7:0], 1'b1};
                                if (bitIdx_r == 4'h8) begin
                                    ack_r <= !sdaSync_r[1];
                                    st_r <= ctrl_r[CTRL_STOP] ? HS_STOP : HS_DONE;
                                end else begin
                                    rdata_r <= {rdata_r[6:0], sdaSync_r[1]};
                                    bitIdx_r <= bitIdx_r + 4'h1;
                                end
                            end
                        end
                        HS_STOP: begin
                            if (!phase_r) begin
                                sclO_r <= 1'b0;
                                sdaO_r <= 1'b0;
                                phase_r <= 1'b1;
                            end else if (!sclO_r) begin
                                sclO_r <= 1'b1;
                            end else begin
                                sdaO_r <= 1'b1;
                                st_r <= HS_IDLE;
                                busy_r <= 1'b0;
                            end
                        end
                        default: begin
                            // hold scl low between bytes
                            sclO_r <= 1'b0;
                            st_r <= HS_IDLE;
                            busy_r <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end
    // driver sequencing
    assign link.sclOut = 1'b0;
    assign link.sclOe = !sclO_r;
    assign link.sdaHostOut = 1'b0;
    assign link.sdaHostOe = !sdaO_r;
endmodule // ccfg_host
`default_nettype wire

// ===== ccfg_link_assertions.sv
// checker watching the two-wire link between host end and device end
`timescale 1ns/1ps
`default_nettype none
module ccfg_link_assertions
    import ccfg_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sdaDevOe,
    input wire logic scl,
    input wire logic sda
);
    logic sclQ_r;
    logic sdaQ_r;
    logic first_r;
    logic rdPhase_r;
    logic nacked_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic rise;
    logic startEv;
    logic stopEv;
    logic ackHigh;
    assign rise = scl && !sclQ_r;
    // counter lags the rise by one edge; cover the first high cycle too
    assign ackHigh = scl && ((cnt_r == 4'h9 && !rise) || (cnt_r == 4'h8 && rise));
    assign startEv = scl && sclQ_r && sdaQ_r && !sda;
    assign stopEv = scl && sclQ_r && !sdaQ_r && sda;
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclQ_r <= 1'b1;
            sdaQ_r <= 1'b1;
        end else begin
            sclQ_r <= scl;
            sdaQ_r <= sda;
        end
    end
    // clock count within a byte; 9 is the acknowledge slot
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            first_r <= 1'b0;
            rdPhase_r <= 1'b0;
            nacked_r <= 1'b0;
        end else if (startEv || stopEv) begin
            cnt_r <= 4'h0;
            first_r <= startEv;
            rdPhase_r <= 1'b0;
            nacked_r <= 1'b0;
        end else if (rise) begin
            cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
            if (cnt_r < 4'h8) begin
                sh_r <= {sh_r[6:0], sda};
            end
            if (cnt_r == 4'h9 && first_r) begin
                first_r <= 1'b0;
                rdPhase_r <= sh_r[0];
            end
            if (cnt_r == 4'h8 && rdPhase_r && sda) begin
                nacked_r <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_dev_edge_low: assert property (!$stable(sdaDevOe) |-> !scl)
        else $error("device data enable moved with clock high");
    a_dev_hold_high: assert property ($rose(scl) |-> $stable(sdaDevOe) [*4])
        else $error("device data not held across clock high");
    a_sda_steady_high: assert property (
        scl && sclQ_r && (sda != sdaQ_r) |-> cnt_r <= 4'h1)
        else $error("data line moved with clock high inside a byte");
    a_wr_ack_only: assert property (
        scl && sdaDevOe && !rdPhase_r |-> cnt_r == 4'h9 || (rise && cnt_r == 4'h8))
        else $error("device drove outside the acknowledge slot");
    a_rd_host_slot: assert property (rdPhase_r && ackHigh |-> !sdaDevOe)
        else $error("device drove during the host acknowledge slot");
    a_addr_match_ack: assert property (first_r && ackHigh |->
        sdaDevOe == (sh_r[7:1] == DEF_TARGET))
        else $error("address acknowledge does not follow target match");
    a_nack_release: assert property (nacked_r |-> !sdaDevOe)
        else $error("device kept driving after host not-acknowledge");
    a_stop_idle: assert property (stopEv |=> !sdaDevOe [*8])
        else $error("device drove the idle line after stop");
endmodule // ccfg_link_assertions
`default_nettype wire

// ===== ccfg_link_if.sv
// two-wire link between host end and device end
`timescale 1ns/1ps
`default_nettype none
interface ccfg_link_if;
    logic sclOut;
    logic sclOe;
    logic sdaHostOut;
    logic sdaHostOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic scl;
    logic sda;
    // open drain: low wins, pull-up otherwise
    assign scl = !(sclOe && !sclOut);
    assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));
    modport host (output sclOut, output sclOe, output sdaHostOut, output sdaHostOe,
        input scl, input sda);
    modport dev (output sdaDevOut, output sdaDevOe, input scl, input sda);
endinterface
`default_nettype wire

// ===== ccfg_pkg.sv
// shared constants for the charger configuration two-wire link
// How it works
// - sample on clock rise, change on fall
// - msb first, data steady while clock high
// - eight bits then one acknowledge clock
// - data fall/rise with clock high: start/stop
// - first byte: seven-bit address plus direction
// - one programmable seven-bit target address
// - write: address, ack, pointer, ack, data
// - up to fifteen more bytes, same page
// - non-volatile commit starts only at stop
// - pointer-only write without stop sets pointer
// - repeated start, read address, data at pointer
// - each host ack advances pointer, next byte
// - host nack then stop ends read
// - 00-0F non-volatile, 31-3F volatile registers
// - 0E bit 2 locks configuration forever
// - shadow access needs 0E[0] and 31[7]
// - host writes documented locations only
// - configuration at 00-05, 07, 0C, 0E, 0F
// - charge current bits 7:4 fast current
// - charge current bits 3:0 pre-charge current
package ccfg_pkg;
    localparam int CLK_MHZ = 200;
    localparam int SCL_HALF_NS = 2500;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ) / 1000;
    localparam int NVM_WRITE_US = 5;
    localparam int NVM_WRITE_CYC = NVM_WRITE_US * CLK_MHZ;
    localparam logic [7:0] ADDR_CHARGE_CUR = 8'h00;
    localparam logic [7:0] ADDR_LOCK_CTRL = 8'h0E;
    localparam logic [7:0] ADDR_CMD = 8'h31;
    localparam logic [7:0] ADDR_VOL_LO = 8'h31;
    localparam logic [7:0] ADDR_VOL_HI = 8'h3F;
    localparam logic [7:0] ADDR_NV_HI = 8'h0F;
    localparam logic [7:0] ADDR_SHADOW_HI = 8'h07;
    localparam logic [15:0] CFG_PRESENT = 16'hD0BF;
    localparam int LOCK_BIT = 2;
    localparam int SHADOW_EN_BIT = 0;
    localparam int CMD_SHADOW_BIT = 7;
    localparam int PAGE_BITS = 4;
    localparam logic [6:0] DEF_TARGET = 7'h5A;
    localparam int NDEV_REGS = 64;
    // host register map over the bus
    localparam logic [7:0] HREG_CTRL = 8'h00;
    localparam logic [7:0] HREG_STATUS = 8'h04;
    localparam logic [7:0] HREG_WDATA = 8'h08;
    localparam logic [7:0] HREG_RDATA = 8'h0C;
    localparam int CTRL_GO = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_STOP = 2;
    localparam int CTRL_READ = 3;
    localparam int CTRL_NACK = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ACK = 1;
endpackage

// ===== tb_charger_config_i2c_slave.sv
// self-checking bench: host end and device end joined over the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin badCount++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_charger_config_i2c_slave
    import ccfg_pkg::*;
;
    localparam int HALF = 8;
    localparam int NVMC = 4;
    localparam logic [7:0] AW = {DEF_TARGET, 1'b0};
    localparam logic [7:0] AR = {DEF_TARGET, 1'b1};
    localparam logic [4:0] S = 5'h02;
    localparam logic [4:0] P = 5'h04;
    localparam logic [4:0] N = 5'h00;
    localparam logic [4:0] RD = 5'h08;
    localparam logic [4:0] RNP = 5'h1C;
    localparam logic [7:0] Z = 8'h00;
    typedef struct packed {logic [4:0] fl; logic [7:0] wd; logic ack; logic [7:0] rd;
        logic [7:0] cc;} ccfg_row_s;
    // page write from 0F wraps to 00; lock written with shadow kept on
    ccfg_row_s rows [36] = '{
        '{S, AW, 1'b1, Z, Z}, '{N, 8'h0F, 1'b1, Z, Z}, '{N, 8'h5A, 1'b1, Z, Z},
        '{N, 8'h11, 1'b1, Z, Z}, '{P, 8'h22, 1'b1, Z, 8'h11},
        '{S, AW, 1'b1, Z, Z}, '{N, 8'h00, 1'b1, Z, Z}, '{S, AR, 1'b1, Z, Z},
        '{RD, Z, 1'b0, 8'h11, Z}, '{RNP, Z, 1'b0, 8'h22, 8'h11},
        '{S | P, 8'hC0, 1'b0, Z, 8'h11},
        '{S, AW, 1'b1, Z, Z}, '{N, 8'h0C, 1'b1, Z, Z}, '{P, 8'h77, 1'b1, Z, 8'h11},
        '{S, AW, 1'b1, Z, Z}, '{N, 8'h0E, 1'b1, Z, Z}, '{P, 8'h01, 1'b1, Z, 8'h11},
        '{S, AW, 1'b1, Z, Z}, '{N, 8'h31, 1'b1, Z, Z}, '{P, 8'h80, 1'b1, Z, 8'h11},
        '{S, AW, 1'b1, Z, Z}, '{N, 8'h00, 1'b1, Z, Z}, '{P, 8'h3C, 1'b1, Z, 8'h3C},
        '{S, AW, 1'b1, Z, Z}, '{N, 8'h0E, 1'b1, Z, Z}, '{P, 8'h05, 1'b1, Z, 8'h3C},
        '{S, AW, 1'b1, Z, Z}, '{N, 8'h0C, 1'b1, Z, Z}, '{P, 8'h99, 1'b1, Z, 8'h3C},
        '{S, AW, 1'b1, Z, Z}, '{N, 8'h0E, 1'b1, Z, Z}, '{P, 8'h00, 1'b1, Z, 8'h3C},
        '{S, AW, 1'b1, Z, Z}, '{N, 8'h0C, 1'b1, Z, Z}, '{S, AR, 1'b1, Z, Z},
        '{RNP, Z, 1'b0, 8'h77, 8'h3C}};
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] chargeCur;
    logic nvmBusy;
    logic locked;
    int badCount = 0;
    int checks = 0;
    always #2.5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////
    ccfg_link_if link();
    ccfg_host #(.HALF_CYC(HALF)) u_ccfg_host(.mclk(mclk), .reset_n(reset_n), .link(link),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp));
    ccfg_dev #(.NVM_CYC(NVMC)) u_ccfg_dev(.mclk(mclk), .reset_n(reset_n), .link(link),
        .chargeCurrent_r(chargeCur), .nvmBusy_r(nvmBusy), .locked_r(locked));
    ccfg_link_assertions u_ccfg_link_assertions(.mclk(mclk), .reset_n(reset_n),
        .sdaDevOe(link.sdaDevOe), .scl(link.scl), .sda(link.sda));
    ////////////////////////////////////////////////////////////////////////////
    // single word transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic byte_op(input logic [4:0] fl, input logic [7:0] wd,
        output logic [31:0] st, output logic [31:0] q);
        int n;
        ahb(1'b1, HREG_WDATA, {24'h0, wd}, q);
        ahb(1'b1, HREG_CTRL, {27'h0, fl | 5'h01}, q);
        n = 0;
        do begin
            ahb(1'b0, HREG_STATUS, 32'h0, st);
            n++;
        end while (st[STAT_BUSY] !== 1'b0 && n < 4000);
        // a poll that runs out of tries counts against the run
        `CHK(st[STAT_BUSY], 1'b0)
        ahb(1'b0, HREG_RDATA, 32'h0, q);
    endtask
    task automatic complete_run();
        if (badCount == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] st;
        logic [31:0] q;
        repeat (20) @(posedge mclk);
        `CHK(link.scl, 1'b1)
        `CHK(link.sda, 1'b1)
        `CHK(locked, 1'b0)
        `CHK(chargeCur, 8'h00)
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 36; i++) begin
            byte_op(rows[i].fl, rows[i].wd, st, q);
            if (!rows[i].fl[3]) `CHK(st[STAT_ACK], rows[i].ack)
            if (rows[i].fl[3]) `CHK(q[7:0], rows[i].rd)
            if (rows[i].fl[2]) begin
                // commit runs its fixed count after stop
                repeat (NVMC + 40) @(posedge mclk);
                `CHK(chargeCur, rows[i].cc)
            end
        end
        `CHK(locked, 1'b1)
        `CHK(nvmBusy, 1'b0)
        ahb(1'b0, 8'h20, 32'h0, q);
        `CHK(q, 32'h0)
        `CHK(hresp, 1'b0)
        complete_run();
    end
    // whole table runs near 7.5k cycles
    initial begin
        repeat (80000) @(posedge mclk);
        badCount++;
        complete_run();
    end
endmodule // tb_charger_config_i2c_slave
`default_nettype wire
